// ==== src/cc_sleep_cfg.svh ====
`ifndef CC_SLEEP_CFG_SVH
`define CC_SLEEP_CFG_SVH

// ************************************************************
// Register map
// ************************************************************
`define OFS_CC_LINE_STATUS 8'h69
`define OFS_SLEEP_SETUP 8'h70

// ************************************************************
// Field codes
// ************************************************************
`define TERM_NONE 8'h00
`define TERM_CODE_MAX 8'h05
`define MSG_LINE_MAX 8'h02
`define THRESH_ALWAYS_AWAKE 8'hff
`define DELAY_CODE_SHORT 3'b011
`define DELAY_CODE_LONG 3'b101
`define SLEEP_RSVD_LSB 4
`define SLEEP_RSVD_MSB 7
`define SLEEP_SRC_BIT 3
`define THRESH_LSB 8
`define THRESH_MSB 15
`define DELAY_LSB 0
`define DELAY_MSB 2
`define DELAY_RSVD_LOW 3'b001
`define DELAY_RSVD_HIGH 3'b111

// ************************************************************
// Timing
// ************************************************************
`define CLK_MHZ 250
`define KHZ_PER_MHZ 1000
`define SLEEP_SHORT_MS 100
`define SLEEP_LONG_MS 1000
`define CNT_W 28

`endif

// ==== src/cc_sleep_pkg.sv ====
`include "cc_sleep_cfg.svh"

package cc_sleep_pkg;

    // Writable sleep setup fields, reserved bits are not stored
    typedef struct packed {
        logic [7:0] threshold;
        logic sleep_while_sourcing;
        logic [2:0] sleep_delay_code;
    } sleep_setup_type;

    // Power state of the controller
    typedef enum logic [3:0] {
        ST_AWAKE = 4'h1,
        ST_WAIT = 4'h2,
        ST_LIGHT = 4'h4,
        ST_DEEP = 4'h8
    } sleep_state_type;

    // Whole module state
    typedef struct packed {
        sleep_setup_type cfg;
        sleep_state_type st;
        logic [`CNT_W-1:0] count;
        logic [31:0] rdata;
        logic ack;
        logic nack;
    } core_state_type;

    // Line status reported by the detection logic
    typedef struct packed {
        logic [7:0] line_two_termination;
        logic [7:0] line_one_termination;
        logic [7:0] messaging_line_select;
    } cc_line_type;

endpackage : cc_sleep_pkg

// ==== src/cc_status_sleep_config_regs.sv ====
`timescale 1ns/1ps
`include "cc_sleep_cfg.svh"

// Operation
// - Status bytes 3 and 2 report line two and line one termination codes.
// - Status byte 1 reports messaging line, reserved values never reported.
// - Sleep byte 2 threshold compared with current power state.
// - Threshold at or below power state allows deep mode that may refuse transfers.
// - Threshold above power state allows only light mode serving every transfer.
// - Threshold 0xff keeps device responsive in every power state.
// - Bit 3 allows sleep while sourcing 5V to a non-messaging sink.
// - Sleep delay code with least bit zero disables sleep.
// - Code 011b waits 100 ms, 101b waits 1000 ms, 001b and 111b reserved.
module cc_status_sleep_config_regs
    import cc_sleep_pkg::*;
#(
    parameter logic [`CNT_W-1:0] SHORT_CYCLES =
        `CNT_W'(`SLEEP_SHORT_MS * `KHZ_PER_MHZ * `CLK_MHZ),
    parameter logic [`CNT_W-1:0] LONG_CYCLES =
        `CNT_W'(`SLEEP_LONG_MS * `KHZ_PER_MHZ * `CLK_MHZ)
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire cc_line_type cc_line_i,
    input wire logic [7:0] power_state_i,
    input wire logic idle_i,
    input wire logic sourcing_5v_i,
    output logic ack_o,
    output logic nack_o,
    output logic [31:0] rdata_o,
    output logic sleep_light_o,
    output logic sleep_deep_o
);

    // ************************************************************
    // State
    // ************************************************************
    localparam core_state_type CORE_RESET = '{
        cfg: '0, st: ST_AWAKE, count: '0, rdata: '0, ack: 1'b0, nack: 1'b0};

    core_state_type s_r;
    core_state_type s_nxt;
    logic sleep_enable;
    logic deep_allowed;
    logic write_hit;
    logic [`CNT_W-1:0] wait_target;

    // Unknown codes from detection are masked so reserved values never escape
    function automatic logic [7:0] clean_code(input logic [7:0] code,
                                              input logic [7:0] max_code);
        clean_code = (code > max_code) ? `TERM_NONE : code;
    endfunction : clean_code

    // ************************************************************
    // Sleep decisions
    // ************************************************************
    always_comb begin
        // reserved codes
        // Reserved delay codes are treated like the never-sleep codes
        sleep_enable = ((s_r.cfg.sleep_delay_code == `DELAY_CODE_SHORT) ||
                        (s_r.cfg.sleep_delay_code == `DELAY_CODE_LONG)) && idle_i;
        if (sourcing_5v_i && !s_r.cfg.sleep_while_sourcing) begin
            sleep_enable = 1'b0;
        end
        deep_allowed = (s_r.cfg.threshold != `THRESH_ALWAYS_AWAKE) &&
                       (s_r.cfg.threshold <= power_state_i);
        wait_target = (s_r.cfg.sleep_delay_code == `DELAY_CODE_SHORT) ?
                      SHORT_CYCLES - 1'b1 : LONG_CYCLES - 1'b1;
        write_hit = req_i && we_i && (addr_i == `OFS_SLEEP_SETUP);
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.nack = 1'b0;
        if (req_i && s_r.st == ST_DEEP) begin
            // refuse in deep
            // Refusal wakes the device so the host retry is served
            s_nxt.nack = 1'b1;
            s_nxt.st = ST_AWAKE;
            s_nxt.count = '0;
        end else begin
            if (req_i) begin
                s_nxt.ack = 1'b1;
                unique case (addr_i)
                    `OFS_CC_LINE_STATUS: begin
                        s_nxt.rdata = {8'h00,
                            clean_code(cc_line_i.line_two_termination, `TERM_CODE_MAX),
                            clean_code(cc_line_i.line_one_termination, `TERM_CODE_MAX),
                            clean_code(cc_line_i.messaging_line_select, `MSG_LINE_MAX)};
                    end
                    `OFS_SLEEP_SETUP: begin
                        s_nxt.rdata = {16'h0000, s_r.cfg.threshold, 4'h0,
                                       s_r.cfg.sleep_while_sourcing,
                                       s_r.cfg.sleep_delay_code};
                    end
                    default: begin
                        s_nxt.rdata = 32'h0000_0000;
                    end
                endcase
            end
            if (write_hit) begin
                s_nxt.cfg.threshold = wdata_i[`THRESH_MSB:`THRESH_LSB];
                s_nxt.cfg.sleep_while_sourcing = wdata_i[`SLEEP_SRC_BIT];
                s_nxt.cfg.sleep_delay_code = wdata_i[`DELAY_MSB:`DELAY_LSB];
            end
            // A new setup restarts the delay so it always applies in full
            if (!sleep_enable || write_hit) begin
                s_nxt.st = ST_AWAKE;
                s_nxt.count = '0;
            end else begin
                unique case (s_r.st)
                    ST_AWAKE: begin
                        s_nxt.st = ST_WAIT;
                        s_nxt.count = '0;
                    end
                    ST_WAIT: begin
                        if (s_r.count == wait_target) begin
                            s_nxt.st = deep_allowed ? ST_DEEP : ST_LIGHT;
                        end else begin
                            s_nxt.count = s_r.count + 1'b1;
                        end
                    end
                    ST_LIGHT, ST_DEEP: begin
                        s_nxt.st = deep_allowed ? ST_DEEP : ST_LIGHT;
                    end
                    default: begin
                        s_nxt.st = ST_AWAKE;
                    end
                endcase
            end
        end
    end

    // Single register for all state
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            s_r <= CORE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ack_o = s_r.ack;
    assign nack_o = s_r.nack;
    assign rdata_o = s_r.rdata;
    assign sleep_light_o = (s_r.st == ST_LIGHT);
    assign sleep_deep_o = (s_r.st == ST_DEEP);

    // ************************************************************
    // Checks
    // ************************************************************
    sequence req_awake_seq;
        req_i && (s_r.st != ST_DEEP);
    endsequence

    sequence wait_done_seq;
        (s_r.st == ST_WAIT) && (s_r.count == wait_target) && sleep_enable && !req_i;
    endsequence

    a_ack_served: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        req_awake_seq |=> ack_o && !nack_o)
        else $error("served request not acknowledged");

    a_deep_refuse: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        req_i && sleep_deep_o |=> nack_o && !ack_o && !sleep_deep_o && !sleep_light_o)
        else $error("deep request not refused");

    a_ff_awake: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_r.cfg.threshold == `THRESH_ALWAYS_AWAKE |-> !sleep_deep_o)
        else $error("deep mode with threshold 0xff");

    a_even_nosleep: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !s_r.cfg.sleep_delay_code[0] |-> s_r.st == ST_AWAKE)
        else $error("sleep with disabled delay code");

    a_rsvd_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        req_awake_seq ##0 (addr_i == `OFS_SLEEP_SETUP) |=>
        rdata_o[`SLEEP_RSVD_MSB:`SLEEP_RSVD_LSB] == 4'h0 && rdata_o[31:16] == 16'h0000)
        else $error("reserved sleep bits not zero");

    a_status_codes: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        req_awake_seq ##0 (addr_i == `OFS_CC_LINE_STATUS) |=>
        rdata_o[23:16] <= `TERM_CODE_MAX && rdata_o[15:8] <= `TERM_CODE_MAX &&
        rdata_o[7:0] <= `MSG_LINE_MAX)
        else $error("reserved status code reported");

    a_source_block: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        sourcing_5v_i && !s_r.cfg.sleep_while_sourcing |=> s_r.st == ST_AWAKE)
        else $error("sleep while sourcing not permitted");

    a_deep_choice: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wait_done_seq |=> (s_r.st == ST_DEEP) == $past(deep_allowed) &&
        (sleep_deep_o || sleep_light_o))
        else $error("wrong sleep depth at delay end");

    a_wait_length: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(sleep_deep_o || sleep_light_o) && $past(s_r.st == ST_WAIT) |->
        $past(s_r.count) == $past(wait_target))
        else $error("sleep entered before delay end");

    // ************************************************************
    // Register port checks
    // ************************************************************
    // A refused request is the first step, the host retry the second
    sequence deep_req_seq;
        req_i && sleep_deep_o;
    endsequence

    // The retry must land, otherwise the host would retry forever
    a_retry_served: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        deep_req_seq ##1 req_i |=> ack_o && !nack_o)
        else $error("retry after refusal not served");

    // A refused write must not change the setup
    a_refuse_cfg: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        deep_req_seq |=> $stable(s_r.cfg))
        else $error("refused write changed setup");

    // A refused read must leave the last read data in place
    a_refuse_data: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        deep_req_seq |=> $stable(rdata_o))
        else $error("refused read changed data");

    // Every request gets exactly one answer
    a_one_answer: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        req_i |=> ack_o != nack_o)
        else $error("request without a single answer");

    // No answer without a request
    a_no_answer: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !req_i |=> !ack_o && !nack_o)
        else $error("answer without a request");

    // Read data stands until the next served request
    a_data_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !req_i |=> $stable(rdata_o))
        else $error("read data changed while idle");

    // Upper status byte carries no field and must read zero
    a_status_top: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        req_awake_seq ##0 (addr_i == `OFS_CC_LINE_STATUS) |=> rdata_o[31:24] == 8'h00)
        else $error("status top byte not zero");

    // Unmapped offsets read as zero so no stale data leaks out
    a_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        req_awake_seq ##0 (addr_i != `OFS_CC_LINE_STATUS && addr_i != `OFS_SLEEP_SETUP) |=>
        rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    // A served write to the setup takes the threshold and the delay code
    a_write_lands: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        req_awake_seq ##0 (we_i && addr_i == `OFS_SLEEP_SETUP) |=>
        s_r.cfg.threshold == $past(wdata_i[`THRESH_MSB:`THRESH_LSB]) &&
        s_r.cfg.sleep_delay_code == $past(wdata_i[`DELAY_MSB:`DELAY_LSB]))
        else $error("setup write not stored");

    // ************************************************************
    // Sleep checks
    // ************************************************************
    // Without deep permission only the light mode may follow
    a_thresh_light: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !deep_allowed |=> !sleep_deep_o)
        else $error("deep mode without permission");

    // A busy device never sleeps; losing idle wakes it the next cycle
    a_busy_awake: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !idle_i |=> s_r.st == ST_AWAKE)
        else $error("asleep while busy");

    // Any sleep mode needs the permission of the cycle before
    a_asleep_idle: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (sleep_light_o || sleep_deep_o) |-> $past(sleep_enable) && $past(idle_i))
        else $error("asleep without permission");

    // Reserved delay codes behave like never sleep
    a_rsvd_delay: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (s_r.cfg.sleep_delay_code == `DELAY_RSVD_LOW ||
         s_r.cfg.sleep_delay_code == `DELAY_RSVD_HIGH) |-> s_r.st == ST_AWAKE)
        else $error("sleep with reserved delay code");

    // Counter never runs past the end of the chosen delay
    a_count_bound: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_r.st == ST_WAIT |-> s_r.count <= wait_target)
        else $error("delay counter overran");

endmodule : cc_status_sleep_config_regs

// ==== verification/cc_host_model.sv ====
`timescale 1ns/1ps

// ****************************************
// Host side of the register port
// ****************************************
module cc_host_model
    import cc_sleep_pkg::*;
(
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic nack_i,
    input wire logic [31:0] rdata_i,
    output logic req_o,
    output logic we_o,
    output logic [7:0] addr_o,
    output logic [31:0] wdata_o
);
    int retries;

    // Idle bus at time zero
    initial begin
        req_o = 1'b0;
        we_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 32'h0;
    end

    // One access; raw lets a scenario leave reserved bits set on purpose
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic raw, output logic [31:0] q);
        int k;
        retries = 0;
        q = 'x;
        for (k = 0; k < 4; k++) begin
            @(posedge clk_i);
            #1;
            req_o = 1'b1;
            we_o = w;
            addr_o = a;
            wdata_o = raw ? d : {d[31:8], 4'h0, d[3:0]};
            @(posedge clk_i);
            #1;
            // Released bus shows inverted address and data, never the stale ones
            req_o = 1'b0;
            addr_o = ~a;
            wdata_o = ~wdata_o;
            if (!(ack_i === 1'b1 || nack_i === 1'b1)) begin
                @(posedge clk_i);
                #1;
            end
            if (ack_i === 1'b1) begin
                q = rdata_i;
                break;
            end
            retries++;
        end
    endtask : xfer
endmodule : cc_host_model

// ==== verification/cc_status_sleep_config_regs_tb_top.sv ====
`timescale 1ns/1ps
`include "cc_sleep_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module cc_status_sleep_config_regs_tb_top
    import cc_sleep_pkg::*;
;
    localparam int SHORT = 10;
    localparam int LONG = 20;
    logic clk, resetn, req, we, ack, nack, sl_light, sl_deep, idle, src5v;
    logic [7:0] addr, pstate;
    logic [31:0] wdata, rdata, q;
    cc_line_type cc_line;
    int n_fail, total_checks, i;

    cc_status_sleep_config_regs #(.SHORT_CYCLES(`CNT_W'(SHORT)), .LONG_CYCLES(`CNT_W'(LONG)))
    cc_status_sleep_config_regs_i (.ref_clk_i(clk), .resetn_i(resetn), .req_i(req), .we_i(we),
        .addr_i(addr), .wdata_i(wdata), .cc_line_i(cc_line), .power_state_i(pstate),
        .idle_i(idle), .sourcing_5v_i(src5v), .ack_o(ack), .nack_o(nack), .rdata_o(rdata),
        .sleep_light_o(sl_light), .sleep_deep_o(sl_deep));

    cc_host_model cc_host_model_i (.clk_i(clk), .ack_i(ack), .nack_i(nack), .rdata_i(rdata),
        .req_o(req), .we_o(we), .addr_o(addr), .wdata_o(wdata));

    // ****************************************
    // Clock, checks and closing
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [7:0] lim(input logic [7:0] c, input logic [7:0] mx);
        return (c <= mx) ? c : `TERM_NONE;
    endfunction : lim

    task automatic wrap_up();
        if (n_fail == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up

    // Program setup, wait for sleep, read back; exp is {deep, light}
    task automatic sleep_case(input logic [2:0] code, input logic b3, src, idl,
                              input logic [7:0] thr, ps, input logic [1:0] exp, input int lo);
        int n;
        logic [31:0] d;
        idle = idl;
        src5v = src;
        pstate = ps;
        cc_host_model_i.xfer(1'b1, `OFS_SLEEP_SETUP, {16'h0, thr, 4'h0, b3, code}, 1'b0, d);
        n = 0;
        while (n < 40 && !(sl_light === 1'b1 || sl_deep === 1'b1)) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK({sl_deep, sl_light}, exp)
        if (exp != 2'b00) `CHK(n >= lo && n <= lo + 4, 1'b1)
        cc_host_model_i.xfer(1'b0, `OFS_SLEEP_SETUP, 32'h0, 1'b0, d);
        `CHK(d, {16'h0, thr, 4'h0, b3, code})
        `CHK(cc_host_model_i.retries, (exp == 2'b10) ? 1 : 0)
    endtask : sleep_case

    // Watchdog: whole run needs well under 5000 cycles
    initial begin
        #(4 * 5000);
        n_fail++;
        wrap_up();
    end

    // Main sequence; power state never driven to 0xff
    initial begin
        n_fail = 0;
        total_checks = 0;
        resetn = 1'b0;
        cc_line = '0;
        pstate = 8'h10;
        idle = 1'b0;
        src5v = 1'b0;
        repeat (8) @(posedge clk);
        #1 resetn = 1'b1;
        cc_host_model_i.xfer(1'b0, `OFS_SLEEP_SETUP, 32'h0, 1'b0, q);
        `CHK(q, 32'h0)
        for (i = 0; i < 8; i++) begin
            cc_line = {8'(i), 8'(7 - i), 8'(i)};
            cc_host_model_i.xfer(1'b1, `OFS_CC_LINE_STATUS, 32'hffff_ffff, 1'b1, q);
            cc_host_model_i.xfer(1'b0, `OFS_CC_LINE_STATUS, 32'h0, 1'b0, q);
            `CHK(q, {8'h0, lim(8'(i), 8'h05), lim(8'(7 - i), 8'h05), lim(8'(i), 8'h02)})
        end
        cc_host_model_i.xfer(1'b1, 8'h71, 32'hffff_ffff, 1'b1, q);
        cc_host_model_i.xfer(1'b0, 8'h71, 32'h0, 1'b0, q);
        `CHK(q, 32'h0)
        cc_host_model_i.xfer(1'b1, `OFS_SLEEP_SETUP, 32'h0000_12fa, 1'b1, q);
        cc_host_model_i.xfer(1'b0, `OFS_SLEEP_SETUP, 32'h0, 1'b0, q);
        `CHK(q, 32'h0000_120a)
        for (i = 0; i < 8; i++) begin
            if (i == 3) sleep_case(3'(i), 1'b0, 1'b0, 1'b1, 8'h20, 8'h10, 2'b01, SHORT);
            else if (i == 5) sleep_case(3'(i), 1'b0, 1'b0, 1'b1, 8'h20, 8'h10, 2'b01, LONG);
            else sleep_case(3'(i), 1'b0, 1'b0, 1'b1, 8'h20, 8'h10, 2'b00, 0);
        end
        sleep_case(3'b011, 1'b0, 1'b0, 1'b0, 8'h20, 8'h10, 2'b00, 0);
        sleep_case(3'b011, 1'b0, 1'b1, 1'b1, 8'h20, 8'h10, 2'b00, 0);
        sleep_case(3'b011, 1'b1, 1'b1, 1'b1, 8'h20, 8'h10, 2'b01, SHORT);
        sleep_case(3'b011, 1'b0, 1'b0, 1'b1, 8'h10, 8'h10, 2'b10, SHORT);
        sleep_case(3'b101, 1'b0, 1'b0, 1'b1, 8'h05, 8'h10, 2'b10, LONG);
        sleep_case(3'b011, 1'b0, 1'b0, 1'b1, 8'h11, 8'h10, 2'b01, SHORT);
        sleep_case(3'b011, 1'b0, 1'b0, 1'b1, 8'hff, 8'hfe, 2'b01, SHORT);
        wrap_up();
    end
endmodule : cc_status_sleep_config_regs_tb_top
